// [common/bfe_mem_if.sv]
`timescale 1ns/100ps
interface bfe_mem_if;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output wr, output rd, output idx, output be, output wdata, input rdata);
  modport mem  (input wr, input rd, input idx, input be, input wdata, output rdata);
endinterface

// [common/bfe_pkg.sv]
package bfe_pkg;
  // configuration space placement
  localparam logic [7:0]  CTRL_OFFSET   = 8'h3e;
  localparam logic [5:0]  CTRL_IDX      = 6'h0f;
  localparam logic [5:0]  EXT_FIRST_IDX = 6'h10;
  localparam int          EXT_WORDS     = 48;
  localparam int          IDX_W         = 6;
  // control field positions and reset value
  localparam int          MA_MODE_BIT   = 5;
  localparam int          RSVD_BIT      = 4;
  localparam int          VGA_BIT       = 3;
  localparam int          ISA_BIT       = 2;
  localparam int          SERR_FWD_BIT  = 1;
  localparam int          PAR_RESP_BIT  = 0;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK  = 16'h002f;
  // legacy video ranges
  localparam logic [31:0] VGA_MEM_LO    = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_HI    = 32'h000bffff;
  localparam logic [31:0] VGA_IO1_LO    = 32'h000003b0;
  localparam logic [31:0] VGA_IO1_HI    = 32'h000003bb;
  localparam logic [31:0] VGA_IO2_LO    = 32'h000003c0;
  localparam logic [31:0] VGA_IO2_HI    = 32'h000003df;
  // legacy isa alias space and master-abort fill
  localparam logic [31:0] ISA_SPACE_TOP = 32'h0000ffff;
  localparam logic [31:0] MA_READ_DATA  = 32'hffffffff;
  localparam logic [31:0] RD_ZERO       = 32'h00000000;
endpackage

// [testbench/bfe_sec_agent.sv]
`timescale 1ns/100ps
// secondary bus error source seen from the far side of the bridge
module bfe_sec_agent (
  // clock
  input  wire logic clk,
  // commands from the bench
  input  wire logic serr_req,
  input  wire logic par_req,
  // error lines into the bridge
  output logic      serr_pin,
  output logic      par_err
);
  // pad is asynchronous, skewed so the synchroniser meets a mid-cycle edge
  initial serr_pin = 1'b0;
  always @(serr_req) serr_pin <= #7 serr_req;
  // command taken at the rising edge, where it is settled, so the bench
  // and this model never race at the falling edge; flag launched a half cycle later
  logic par_hold;
  initial par_hold = 1'b0;
  always @(posedge clk) par_hold <= par_req;
  initial par_err = 1'b0;
  always @(negedge clk) par_err <= par_hold;
endmodule

// [testbench/bfe_top_test.sv]
`timescale 1ns/100ps
module bfe_top_test;
  logic        clk, reset, cfg_wr, cfg_rd, cfg_rvalid, cmd_serr_en, serr_req, par_req;
  logic        pri_mem_win_hit, sec_mem_win_hit, dn_req, dn_is_io, dn_ack, dn_fwd;
  logic        up_req, up_is_io, up_ack, up_fwd, ma_event, ma_is_read, ma_posted_done;
  logic        ma_rdata_valid, ma_discard, ma_target_abort, downstream_system_error_in;
  logic        sec_parity_err, upstream_system_error_out, downstream_parity_error_out;
  logic        ed, eu;
  logic [5:0]  cfg_idx;
  logic [3:0]  cfg_be;
  logic [8:0]  f;
  logic [31:0] cfg_wdata, cfg_rdata, io_base, io_limit, dn_addr, up_addr, ma_rdata, rd, v;
  logic [31:0] ext_m [16:63];
  int          err_total, compares, seed, i;

  // design and far-side error source
  bfe_top u_dut (.clk, .reset, .cfg_wr, .cfg_rd, .cfg_idx, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_rvalid, .cmd_serr_en, .io_base, .io_limit, .pri_mem_win_hit, .sec_mem_win_hit,
    .dn_req, .dn_is_io, .dn_addr, .dn_ack, .dn_fwd, .up_req, .up_is_io, .up_addr, .up_ack,
    .up_fwd, .ma_event, .ma_is_read, .ma_posted_done, .ma_rdata, .ma_rdata_valid,
    .ma_discard, .ma_target_abort, .downstream_system_error_in, .sec_parity_err,
    .upstream_system_error_out, .downstream_parity_error_out);
  bfe_sec_agent u_agent (.clk, .serr_req, .par_req, .serr_pin(downstream_system_error_in),
    .par_err(sec_parity_err));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one idle edge first, so back-to-back writes never re-raise the strobe at once
  task automatic cfg_w(logic [5:0] x, logic [3:0] b, logic [31:0] d);
    @(negedge clk);
    {cfg_idx, cfg_be, cfg_wdata, cfg_wr} = {x, b, d, 1'b1};
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  // read answer stands one cycle, so at most one capture in the bounded wait
  task automatic cfg_r(logic [5:0] x, output logic [31:0] d);
    {cfg_idx, cfg_rd, d} = {x, 1'b1, 32'hxxxxxxxx};
    repeat (4)
    begin
      @(negedge clk);
      cfg_rd = 1'b0;
      if (cfg_rvalid === 1'b1)
        d = cfg_rdata;
    end
  endtask

  // one-shot requests dropped after one edge; answer pulses are or-ed up
  task automatic watch;
    {f, rd} = '0;
    repeat (3)
    begin
      @(negedge clk);
      {dn_req, up_req, ma_event, par_req} = 4'h0;
      f |= {dn_ack, dn_fwd, up_ack, up_fwd, ma_rdata_valid, ma_discard, ma_target_abort,
            upstream_system_error_out, downstream_parity_error_out};
      if (ma_rdata_valid === 1'b1)
        rd = ma_rdata;
    end
  endtask

  function automatic logic vid(logic io, logic [31:0] a);
    if (io)
      return (a >= 32'h000003b0 && a <= 32'h000003bb) || (a >= 32'h000003c0 && a <= 32'h000003df);
    return a >= 32'h000a0000 && a <= 32'h000bffff;
  endfunction

  function automatic logic inwin(logic [31:0] a);
    return a >= io_base && a <= io_limit;
  endfunction

  // edge addresses of every range, or a random one near the window
  function automatic logic [31:0] pick(logic r);
    logic [31:0] t [10] = '{32'h000a0000, 32'h000bffff, 32'h000003b0, 32'h000003bb,
      32'h000003c0, 32'h000003df, 32'h000003e0, 32'h000000ff, 32'h0000ffff, 32'h00013fff};
    return r ? $random(seed) & 32'h0001ffff : t[$unsigned($random(seed)) % 10];
  endfunction

  initial
  begin
    {cfg_wr, cfg_rd, cfg_idx, cfg_be, cfg_wdata, cmd_serr_en, serr_req, par_req} = '0;
    {dn_req, dn_is_io, dn_addr, up_req, up_is_io, up_addr, ma_event, ma_is_read} = '0;
    {ma_posted_done, pri_mem_win_hit, sec_mem_win_hit, err_total, compares} = '0;
    {io_base, io_limit, seed, reset} = {32'h00000100, 32'h00013fff, 32'h0636, 1'b1};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    cfg_r(6'h0f, rd);
    chk(rd, 32'h00000000);
    cfg_w(6'h0f, 4'hf, 32'hffffffff);
    cfg_r(6'h0f, rd);
    chk(rd, 32'h002f0000);
    cfg_w(6'h0f, 4'h8, 32'h00000000);
    cfg_w(6'h03, 4'hf, 32'hffffffff);
    cfg_r(6'h03, rd);
    chk(rd, 32'h00000000);
    cfg_r(6'h0f, rd);
    chk(rd, 32'h002f0000);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    cfg_r(6'h0f, rd);
    chk(rd, 32'h00000000);
    for (i = 16; i < 64; i++)
    begin
      ext_m[i] = $random(seed);
      cfg_w(i[5:0], 4'hf, ext_m[i]);
    end
    for (i = 16; i < 64; i++)
    begin
      cfg_r(i[5:0], rd);
      chk(rd, ext_m[i]);
    end
    for (i = 0; i < 300; i++)
    begin
      v = $random(seed);
      cfg_w(6'h0f, 4'h4, {12'h000, v[0], v[1], 18'h00000});
      {dn_addr, up_addr} = {pick(v[2]), pick(v[3])};
      {dn_is_io, up_is_io, pri_mem_win_hit, sec_mem_win_hit} = v[7:4];
      {dn_req, up_req} = 2'b11;
      watch;
      ed = (v[0] && vid(v[7], dn_addr)) || (v[7] ? inwin(dn_addr) &&
           !(v[1] && dn_addr <= 32'h0000ffff && dn_addr[9:8] != 2'b00) : v[5]);
      eu = !(v[0] && vid(v[6], up_addr)) && (v[6] ? !inwin(up_addr) ||
           (v[1] && up_addr[9:8] != 2'b00) : !v[4]);
      chk(f[8:5], {1'b1, ed, 1'b1, eu});
    end
    for (i = 0; i < 16; i++)
    begin
      cfg_w(6'h0f, 4'h4, {10'h000, i[0], 21'h000000});
      {cmd_serr_en, ma_is_read, ma_posted_done, ma_event} = {i[3], i[1], i[2] & !i[1], 1'b1};
      watch;
      chk(f[4:1], {!i[0] & i[1], !i[0] & !i[1], i[0] & !ma_posted_done,
                   i[0] & ma_posted_done & i[3]});
      if (f[4] === 1'b1)
        chk(rd, 32'hffffffff);
    end
    for (i = 0; i < 4; i++)
    begin
      cfg_w(6'h0f, 4'h4, {14'h0000, i[0], i[0], 16'h0000});
      {cmd_serr_en, serr_req} = {i[1], 1'b1};
      repeat (8) @(negedge clk);
      chk(upstream_system_error_out, i[0] & i[1]);
      serr_req = 1'b0;
      repeat (8) @(negedge clk);
      chk(upstream_system_error_out, 1'b0);
      par_req = 1'b1;
      watch;
      chk(f[0], i[0]);
    end
    wrap_up;
  end
endmodule

// [verilog/bfe_ext_mem.sv]
`timescale 1ns/100ps
module bfe_ext_mem #(
  parameter int WORDS = 48
) (
  // clock
  input wire logic clk,
  // access port
  bfe_mem_if.mem   port
);
  logic in_range;

  // words beyond the array are never written and read as zero
  assign in_range = (32'(port.idx) < WORDS);

  // one memory and one read register per lane, so no variable has two writers
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    logic [7:0] lane_q [WORDS];
    logic [7:0] lane_rd_ff;

    // byte write; no reset, contents are software's
    always_ff @(posedge clk)
    begin
      if (port.wr && port.be[b] && in_range)
        lane_q[port.idx] <= port.wdata[8*b +: 8];
    end

    // registered read
    always_ff @(posedge clk)
    begin
      if (port.rd)
        lane_rd_ff <= in_range ? lane_q[port.idx] : 8'h00;
    end

    assign port.rdata[8*b +: 8] = lane_rd_ff;
  end
endmodule

// [verilog/bfe_top.sv]
`timescale 1ns/100ps
// How it works
// [RL1] abort reporting off: reads return all ones, writes accepted and dropped
// [RL2] abort reporting on, posted write done: raise upstream error if command enables it
// [RL3] abort reporting on, not yet done: answer requester with target abort
// [RL4] abort reporting control resets cleared
// [RL5] control bit four reads zero, writes ignored
// [RL6] video on: legacy video memory and io forwarded downstream regardless of windows
// [RL7] video on: legacy video addresses never forwarded upstream
// [RL8] reset clears video forwarding control
// [RL9] isa on: downstream io in window, first 64K, top 768 of 1K refused
// [RL10] isa on: upstream io in window hitting top 768 of 1K forwarded
// [RL11] isa off: every io address inside base/limit window forwarded downstream
// [RL12] secondary error relayed upstream only if forward bit and command enable set
// [RL13] parity response on: detected secondary parity errors drive parity error out
// [RL14] parity response off: secondary parity errors ignored
// [RL15] extension registers 40h-FFh reachable by configuration reads and writes
// [RL16] control register at 3Eh, sixteen bits, resets to zero
module bfe_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // configuration access, dword index, answer two cycles after rd
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [5:0]  cfg_idx,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // settings held in other header registers
  input  wire logic        cmd_serr_en,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  input  wire logic        pri_mem_win_hit,
  input  wire logic        sec_mem_win_hit,
  // primary to secondary decode
  input  wire logic        dn_req,
  input  wire logic        dn_is_io,
  input  wire logic [31:0] dn_addr,
  output logic             dn_ack,
  output logic             dn_fwd,
  // secondary to primary decode
  input  wire logic        up_req,
  input  wire logic        up_is_io,
  input  wire logic [31:0] up_addr,
  output logic             up_ack,
  output logic             up_fwd,
  // master abort seen while bridge is master
  input  wire logic        ma_event,
  input  wire logic        ma_is_read,
  input  wire logic        ma_posted_done,
  output logic      [31:0] ma_rdata,
  output logic             ma_rdata_valid,
  output logic             ma_discard,
  output logic             ma_target_abort,
  // error signalling
  input  wire logic        downstream_system_error_in,
  input  wire logic        sec_parity_err,
  output logic             upstream_system_error_out,
  output logic             downstream_parity_error_out
);
  bfe_mem_if ext ();

  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic        serr_meta_ff;
  logic        serr_sync_ff;
  logic        rd1_ff;
  logic        rd1_ext_ff;
  logic [31:0] rd1_data_ff;

  // field views of the control register
  wire ma_mode  = ctrl_ff[bfe_pkg::MA_MODE_BIT];
  wire vga_en   = ctrl_ff[bfe_pkg::VGA_BIT];
  wire isa_en   = ctrl_ff[bfe_pkg::ISA_BIT];
  wire serr_fwd = ctrl_ff[bfe_pkg::SERR_FWD_BIT];
  wire par_resp = ctrl_ff[bfe_pkg::PAR_RESP_BIT];

  // access decode; the control word is the upper half of dword 0Fh
  wire ctrl_hit   = (cfg_idx == bfe_pkg::CTRL_IDX);
  wire ext_hit    = (cfg_idx >= bfe_pkg::EXT_FIRST_IDX);
  wire ctrl_wr    = cfg_wr && ctrl_hit;
  wire [15:0] wr_val = {cfg_be[3] ? cfg_wdata[31:24] : ctrl_ff[15:8],
                        cfg_be[2] ? cfg_wdata[23:16] : ctrl_ff[7:0]};

  // [RL5] reserved bit masked
  assign nxt_ctrl = ctrl_wr ? (wr_val & bfe_pkg::CTRL_WR_MASK) : ctrl_ff;

  // [RL4] [RL8] [RL16] control resets to zero
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_ff <= bfe_pkg::CTRL_RESET;
    else
      ctrl_ff <= nxt_ctrl;
  end

  // [RL15] extension window passed to the memory
  assign ext.wr    = cfg_wr && ext_hit;
  assign ext.rd    = cfg_rd && ext_hit;
  assign ext.idx   = cfg_idx - bfe_pkg::EXT_FIRST_IDX;
  assign ext.be    = cfg_be;
  assign ext.wdata = cfg_wdata;

  bfe_ext_mem #(
    .WORDS (bfe_pkg::EXT_WORDS)
  ) u_ext (
    .clk   (clk),
    .port  (ext.mem)
  );

  // read path in two stages so memory and control answer at the same time
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd1_ff      <= 1'b0;
      rd1_ext_ff  <= 1'b0;
      rd1_data_ff <= bfe_pkg::RD_ZERO;
      cfg_rvalid  <= 1'b0;
      cfg_rdata   <= bfe_pkg::RD_ZERO;
    end
    else
    begin
      rd1_ff      <= cfg_rd;
      rd1_ext_ff  <= cfg_rd && ext_hit;
      rd1_data_ff <= (cfg_rd && ctrl_hit) ? {ctrl_ff, 16'h0000} : bfe_pkg::RD_ZERO;
      cfg_rvalid  <= rd1_ff;
      cfg_rdata   <= rd1_ext_ff ? ext.rdata : rd1_data_ff;
    end
  end

  // address range decode
  wire dn_vga_mem = (dn_addr >= bfe_pkg::VGA_MEM_LO) && (dn_addr <= bfe_pkg::VGA_MEM_HI);
  wire dn_vga_io  = ((dn_addr >= bfe_pkg::VGA_IO1_LO) && (dn_addr <= bfe_pkg::VGA_IO1_HI)) ||
                    ((dn_addr >= bfe_pkg::VGA_IO2_LO) && (dn_addr <= bfe_pkg::VGA_IO2_HI));
  wire up_vga_mem = (up_addr >= bfe_pkg::VGA_MEM_LO) && (up_addr <= bfe_pkg::VGA_MEM_HI);
  wire up_vga_io  = ((up_addr >= bfe_pkg::VGA_IO1_LO) && (up_addr <= bfe_pkg::VGA_IO1_HI)) ||
                    ((up_addr >= bfe_pkg::VGA_IO2_LO) && (up_addr <= bfe_pkg::VGA_IO2_HI));
  wire dn_vga     = vga_en && (dn_is_io ? dn_vga_io : dn_vga_mem);
  wire up_vga     = vga_en && (up_is_io ? up_vga_io : up_vga_mem);
  wire dn_in_win  = (dn_addr >= io_base) && (dn_addr <= io_limit);
  wire up_in_win  = (up_addr >= io_base) && (up_addr <= io_limit);
  // top 768 bytes of a 1K block: offset bits 9:8 not both zero
  wire dn_alias   = (dn_addr[9:8] != 2'b00) && (dn_addr <= bfe_pkg::ISA_SPACE_TOP);
  wire up_alias   = (up_addr[9:8] != 2'b00);

  // [RL6] [RL9] [RL11] downstream claim
  wire dn_claim = dn_vga ||
                  (dn_is_io ? (dn_in_win && !(isa_en && dn_alias)) : pri_mem_win_hit);
  // [RL7] [RL10] upstream claim, video addresses held back whenever video is on
  wire up_claim = !up_vga &&
                  (up_is_io ? (!up_in_win || (isa_en && up_alias)) : !sec_mem_win_hit);

  // decode answers, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dn_ack <= 1'b0;
      dn_fwd <= 1'b0;
      up_ack <= 1'b0;
      up_fwd <= 1'b0;
    end
    else
    begin
      dn_ack <= dn_req;
      dn_fwd <= dn_req && dn_claim;
      up_ack <= up_req;
      up_fwd <= up_req && up_claim;
    end
  end

  // [RL1] [RL3] master abort outcome
  wire ma_quiet   = ma_event && !ma_mode;
  wire ma_report  = ma_event && ma_mode;
  // [RL2] posted write abort raises upstream error
  wire ma_serr    = ma_report && ma_posted_done && cmd_serr_en;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ma_rdata        <= bfe_pkg::RD_ZERO;
      ma_rdata_valid  <= 1'b0;
      ma_discard      <= 1'b0;
      ma_target_abort <= 1'b0;
    end
    else
    begin
      ma_rdata        <= (ma_quiet && ma_is_read) ? bfe_pkg::MA_READ_DATA : bfe_pkg::RD_ZERO;
      ma_rdata_valid  <= ma_quiet && ma_is_read;
      ma_discard      <= ma_quiet && !ma_is_read;
      ma_target_abort <= ma_report && !ma_posted_done;
    end
  end

  // secondary error pin is asynchronous to us; two flops before use
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      serr_meta_ff <= 1'b0;
      serr_sync_ff <= 1'b0;
    end
    else
    begin
      serr_meta_ff <= downstream_system_error_in;
      serr_sync_ff <= serr_meta_ff;
    end
  end

  // [RL12] relay gated by both enables
  wire serr_relay = serr_sync_ff && serr_fwd && cmd_serr_en;

  // [RL13] [RL14] parity report gated by response enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      upstream_system_error_out   <= 1'b0;
      downstream_parity_error_out <= 1'b0;
    end
    else
    begin
      upstream_system_error_out   <= serr_relay || ma_serr;
      downstream_parity_error_out <= sec_parity_err && par_resp;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_quiet_read;
    ma_event && !ma_mode && ma_is_read;
  endsequence
  sequence s_all_ones;
    ma_rdata_valid && (ma_rdata == bfe_pkg::MA_READ_DATA);
  endsequence

  chk_abort_all_ones: assert property (s_quiet_read |=> s_all_ones) // [RL1]
    else $error("quiet master abort read did not return all ones");
  chk_abort_serr: assert property ( // [RL2]
    (ma_event && ma_mode && ma_posted_done && cmd_serr_en) |=> upstream_system_error_out)
    else $error("posted write abort did not raise upstream error");
  chk_target_abort: assert property ( // [RL3]
    ma_target_abort == $past(ma_event && ma_mode && !ma_posted_done))
    else $error("target abort does not match abort report condition");
  chk_rsvd_zero: assert property (ctrl_ff[bfe_pkg::RSVD_BIT] == 1'b0) // [RL5]
    else $error("reserved control bit became set");
  chk_video_down: assert property ( // [RL6]
    (dn_req && vga_en && dn_is_io && dn_addr == bfe_pkg::VGA_IO2_HI) |=> dn_fwd)
    else $error("legacy video io not forwarded downstream");
  chk_video_up: assert property ((up_req && up_vga) |=> (up_ack && !up_fwd)) // [RL7]
    else $error("legacy video address forwarded upstream");
  chk_isa_block: assert property ( // [RL9]
    (dn_req && dn_is_io && isa_en && dn_alias && !vga_en) |=> !dn_fwd)
    else $error("isa alias forwarded downstream");
  chk_serr_gate: assert property ( // [RL12]
    upstream_system_error_out |-> ($past(cmd_serr_en) &&
      ($past(serr_sync_ff && serr_fwd) || $past(ma_serr))))
    else $error("upstream error raised without enables");
  chk_parity_ignore: assert property (!par_resp |=> !downstream_parity_error_out) // [RL14]
    else $error("parity error reported while response disabled");
  chk_ctrl_read: assert property ( // [RL16]
    (cfg_rd && ctrl_hit) |-> ##2 (cfg_rvalid && cfg_rdata[31:16] == $past(ctrl_ff, 2)))
    else $error("control read data wrong");
endmodule
